/* File: hdl/pulse_scan_tap.sv */
// boundary-scan tap with pulsed and training external-test instructions
`timescale 1ns/1ns
`include "pulse_scan_params.svh"
module pulse_scan_tap #(
  parameter int BSR_WIDTH = `BSR_WIDTH_DEFAULT
) (
  // clock and reset
  input  wire logic                 MCLK,
  input  wire logic                 RESET_N,
  // jtag pins from the tester
  input  wire logic                 TCK,
  input  wire logic                 TMS,
  input  wire logic                 TDI,
  output logic                      TDO,
  output logic                      TDO_OE,
  // configuration status, same clock domain
  input  wire logic                 CONFIG_DONE,
  // core side of the boundary pins
  input  wire logic [BSR_WIDTH-1:0] CORE_OUT,
  input  wire logic [BSR_WIDTH-1:0] PIN_IN,
  // boundary pin drivers
  output logic      [BSR_WIDTH-1:0] PIN_OUT,
  output logic                      TEST_ACTIVE
);
  import pulse_scan_pkg::*;

  localparam int IRW = `IR_WIDTH;

  logic [2:0]           jtag_level;
  logic                 tck_prev;
  logic                 tck_rise;
  logic                 tck_fall;
  logic                 tms_s;
  logic                 tdi_s;
  pulse_scan_pkg::tap_state_t state;
  pulse_scan_pkg::tap_state_t next_state;
  logic [IRW-1:0]       ir_shift;
  logic [IRW-1:0]       ir;
  logic [IRW-1:0]       next_ir;
  logic [BSR_WIDTH-1:0] bsr_shift;
  logic [BSR_WIDTH-1:0] upd;
  logic                 bypass_bit;
  logic                 bsr_sel;
  logic                 was_idle;
  logic                 ext_now;
  logic                 ext_next;
  logic                 pulse_next;
  logic                 train_next;

  initial begin
    if (BSR_WIDTH < 1) $error("BSR_WIDTH must be at least one");
  end

  // pulsed and training codes count only after configuration
  function automatic logic is_pulse(input logic [IRW-1:0] c,
                                    input logic cfg);
    is_pulse = (c == `IR_PULSED_EXTEST) && cfg;
  endfunction

  function automatic logic is_train(input logic [IRW-1:0] c,
                                    input logic cfg);
    is_train = (c == `IR_TRAINING_TEST) && cfg;
  endfunction

  function automatic logic is_ext(input logic [IRW-1:0] c,
                                  input logic cfg);
    is_ext = (c == `IR_PLAIN_EXTEST) || is_pulse(c, cfg) ||
             is_train(c, cfg);
  endfunction

  // the tester clock is just another pin, sampled by MCLK
  pin_filter #(
    .WIDTH (3)
  ) u_jtag_filter (
    .clk     (MCLK),
    .reset_n (RESET_N),
    .pin     ({TCK, TMS, TDI}),
    .level   (jtag_level)
  );

  assign tms_s    = jtag_level[1];
  assign tdi_s    = jtag_level[0];
  assign tck_rise = jtag_level[2] & ~tck_prev;
  assign tck_fall = ~jtag_level[2] & tck_prev;

  // previous filtered tck for edge detection
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      tck_prev <= 1'b0;
    end else begin
      tck_prev <= jtag_level[2];
    end
  end

  // standard tap transition table
  always_comb begin
    next_state = TAP_TLR;
    case (state)
      TAP_TLR:    next_state = tms_s ? TAP_TLR    : TAP_RTI;
      TAP_RTI:    next_state = tms_s ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_DR: next_state = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: next_state = tms_s ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  next_state = tms_s ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: next_state = tms_s ? TAP_UP_DR  : TAP_PA_DR;
      TAP_PA_DR:  next_state = tms_s ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: next_state = tms_s ? TAP_UP_DR  : TAP_SH_DR;
      TAP_UP_DR:  next_state = tms_s ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_IR: next_state = tms_s ? TAP_TLR    : TAP_CAP_IR;
      TAP_CAP_IR: next_state = tms_s ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  next_state = tms_s ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: next_state = tms_s ? TAP_UP_IR  : TAP_PA_IR;
      TAP_PA_IR:  next_state = tms_s ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: next_state = tms_s ? TAP_UP_IR  : TAP_SH_IR;
      TAP_UP_IR:  next_state = tms_s ? TAP_SEL_DR : TAP_RTI;
      default:    next_state = TAP_TLR;
    endcase
  end

  // tap state advances on rising tck
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      state <= TAP_TLR;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // instruction shift path, captured and shifted on rising tck
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      ir_shift <= `IR_CAPTURE_VALUE;
    end else if (tck_rise) begin
      if (state == TAP_CAP_IR) begin
        ir_shift <= `IR_CAPTURE_VALUE;
      end else if (state == TAP_SH_IR) begin
        ir_shift <= {tdi_s, ir_shift[IRW-1:1]};
      end
    end
  end

  // active instruction loads on the falling edge in Update-IR
  assign next_ir = (state == TAP_UP_IR) ? ir_shift : ir;
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      ir <= `IR_BYPASS_RESET;
    end else if (state == TAP_TLR) begin
      ir <= `IR_BYPASS_RESET;
    end else if (tck_fall) begin
      ir <= next_ir;
    end
  end

  assign bsr_sel    = is_ext(ir, CONFIG_DONE) || (ir == `IR_SAMPLE);
  assign ext_now    = is_ext(ir, CONFIG_DONE);
  assign ext_next   = is_ext(next_ir, CONFIG_DONE);
  assign pulse_next = is_pulse(next_ir, CONFIG_DONE);
  assign train_next = is_train(next_ir, CONFIG_DONE);

  // data registers: boundary chain or one-bit bypass
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      bsr_shift  <= '0;
      bypass_bit <= 1'b0;
    end else if (tck_rise) begin
      if (state == TAP_CAP_DR) begin
        bsr_shift  <= PIN_IN;
        bypass_bit <= 1'b0;
      end else if (state == TAP_SH_DR) begin
        if (bsr_sel) begin
          bsr_shift <= {tdi_s, bsr_shift[BSR_WIDTH-1:1]};
        end
        bypass_bit <= tdi_s;
      end
    end
  end

  // tdo changes on falling tck, so the tester samples it stable
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      TDO    <= 1'b0;
      TDO_OE <= 1'b0;
    end else if (tck_fall) begin
      TDO_OE <= (state == TAP_SH_IR) || (state == TAP_SH_DR);
      if (state == TAP_SH_IR) begin
        TDO <= ir_shift[0];
      end else if (bsr_sel) begin
        TDO <= bsr_shift[0];
      end else begin
        TDO <= bypass_bit;
      end
    end
  end

  // update latch and idle history, both on falling tck
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      upd      <= '0;
      was_idle <= 1'b0;
    end else if (tck_fall) begin
      was_idle <= (state == TAP_RTI);
      if (state == TAP_UP_DR && bsr_sel) begin
        upd <= bsr_shift;
      end
    end
  end

  // pin drivers: core data in mission mode, boundary data under test
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      PIN_OUT     <= {BSR_WIDTH{`PIN_RESET_VALUE}};
      TEST_ACTIVE <= 1'b0;
    end else if (tck_fall && ext_next) begin
      TEST_ACTIVE <= 1'b1;
      if (state == TAP_UP_DR) begin
        PIN_OUT <= bsr_shift;
      end else if (state == TAP_UP_IR) begin
        PIN_OUT <= upd;
      end else if (state == TAP_RTI && (pulse_next || train_next)) begin
        if (!was_idle) begin
          PIN_OUT <= ~upd;
        end else if (train_next) begin
          PIN_OUT <= ~PIN_OUT;
        end
      end else if (was_idle && state != TAP_RTI) begin
        PIN_OUT <= upd;
      end
    end else if (!ext_now && !(tck_fall && ext_next)) begin
      // config loss mid pulsed or training test drops straight back to core data
      PIN_OUT     <= CORE_OUT;
      TEST_ACTIVE <= 1'b0;
    end
  end

  // checks on the block's own behaviour
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  AST_PULSE_DECODE: assert property (
    tck_fall && state == TAP_UP_IR && ir_shift == `IR_PULSED_EXTEST &&
    CONFIG_DONE |=> ir == `IR_PULSED_EXTEST ##1 TEST_ACTIVE)
    else $error("pulsed code not decoded");

  AST_UPDATE_DRIVE: assert property (
    tck_fall && ext_next && state == TAP_UP_DR |=> PIN_OUT == upd)
    else $error("update did not present boundary data");

  AST_IDLE_INVERT: assert property (
    tck_fall && pulse_next && state == TAP_RTI && !was_idle
    |=> PIN_OUT == ~upd && was_idle)
    else $error("no inverted pulse on entering idle");

  AST_LEAVE_RESTORE: assert property (
    tck_fall && ext_next && was_idle && state == TAP_SEL_DR
    |=> PIN_OUT == upd)
    else $error("data not restored after idle");

  AST_TRAIN_DECODE: assert property (
    ir == `IR_TRAINING_TEST && CONFIG_DONE |-> ext_now && bsr_sel)
    else $error("training code not decoded as external test");

  AST_TRAIN_TOGGLE: assert property (
    tck_fall && train_next && state == TAP_RTI && was_idle
    |=> PIN_OUT == ~$past(PIN_OUT))
    else $error("training output did not toggle");

  AST_CONFIG_GATE: assert property (
    !CONFIG_DONE && (ir == `IR_PULSED_EXTEST || ir == `IR_TRAINING_TEST)
    |=> !TEST_ACTIVE)
    else $error("pulsed test honoured before configuration");

  AST_TAP_RESET: assert property (
    (tck_rise && tms_s && state == TAP_SEL_IR)
    |=> state == TAP_TLR ##1 ir == `IR_BYPASS_RESET)
    else $error("tap did not reach reset");

  CVR_PULSE_RUN: cover property (
    tck_fall && pulse_next && state == TAP_RTI && !was_idle);
  CVR_TRAIN_RUN: cover property (
    tck_fall && train_next && state == TAP_RTI && was_idle);
  CVR_LEAVE_IDLE: cover property (
    tck_fall && ext_next && was_idle && state == TAP_SEL_DR);
endmodule

/* File: hdl/pulse_scan_params.svh */
// constants for the pulsed boundary-scan test port
// Operation
// - instruction 0010001111 selects pulsed external test with an inverted pulse
// - pulsed test drives boundary data on TCK fall in Update-IR or Update-DR
// - pulsed test drives inverted data on TCK fall after entering Run-Test/Idle
// - pulsed test restores true data on TCK fall after leaving Run-Test/Idle
// - instruction 0001001111 selects training test, otherwise like pulsed test
// - training test inverts outputs every TCK fall while in Run-Test/Idle
// - pulsed and training tests only honoured once configuration has completed
`ifndef PULSE_SCAN_PARAMS_SVH
`define PULSE_SCAN_PARAMS_SVH
`define IR_WIDTH          10
`define IR_PULSED_EXTEST  10'h08F
`define IR_TRAINING_TEST  10'h04F
`define IR_PLAIN_EXTEST   10'h000
`define IR_SAMPLE         10'h005
`define IR_BYPASS_RESET   10'h3FF
`define IR_CAPTURE_VALUE  10'h001
`define BSR_WIDTH_DEFAULT 8
`define PIN_RESET_VALUE   1'b0
`endif

/* File: hdl/pulse_scan_pkg.sv */
// types shared by the pulsed boundary-scan test port
package pulse_scan_pkg;
  // tap controller states, one-hot
  typedef enum logic [15:0] {
    TAP_TLR    = 16'h0001,
    TAP_RTI    = 16'h0002,
    TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008,
    TAP_SH_DR  = 16'h0010,
    TAP_EX1_DR = 16'h0020,
    TAP_PA_DR  = 16'h0040,
    TAP_EX2_DR = 16'h0080,
    TAP_UP_DR  = 16'h0100,
    TAP_SEL_IR = 16'h0200,
    TAP_CAP_IR = 16'h0400,
    TAP_SH_IR  = 16'h0800,
    TAP_EX1_IR = 16'h1000,
    TAP_PA_IR  = 16'h2000,
    TAP_EX2_IR = 16'h4000,
    TAP_UP_IR  = 16'h8000
  } tap_state_t;
endpackage

/* File: hdl/pin_filter.sv */
// three-stage pin synchroniser that accepts a change once stages agree
`timescale 1ns/1ns
module pin_filter #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // pin side and filtered level
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  initial begin
    if (WIDTH < 1) $error("pin_filter width must be positive");
  end

  // stage1 feeds only stage2, so metastability never reaches logic
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // per bit: the level moves only when the last two stages agree
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        level[i] <= 1'b0;
      end else if (stage2[i] == stage3[i]) begin
        level[i] <= stage3[i];
      end
    end
  end
endmodule

/* File: testbench/jtag_tester.sv */
// behavioural boundary-scan tester that drives the tap pins
`timescale 1ns/1ns
module jtag_tester (
  // system clock, only used to pace the pins
  input  wire logic MCLK,
  // tester pins
  output logic      TCK,
  output logic      TMS,
  output logic      TDI,
  input  wire logic TDO,
  input  wire logic TDO_OE
);
  logic last_tdo;
  logic last_oe;
  logic oe_seen;

  // tck stands low outside frames
  initial begin
    TCK = 1'b0;
    TMS = 1'b1;
    TDI = 1'b0;
  end

  // one tck period of 21 mclk; tms and tdi held through the high phase
  task automatic tick(input logic tms, input logic tdi);
    @(posedge MCLK);
    TMS <= tms;
    TDI <= tdi;
    repeat (9) @(posedge MCLK);
    last_tdo = TDO;
    last_oe = TDO_OE;
    @(posedge MCLK);
    TCK <= ~TCK;
    repeat (10) @(posedge MCLK);
    TCK <= ~TCK;
  endtask

  // tdi is not meaningful here, so it flips rather than hold the last bit
  task automatic move(input logic tms);
    tick(tms, ~TDI);
  endtask

  // five ones reach test-logic-reset from any state, then idle
  task automatic tap_reset();
    repeat (5) move(1'b1);
    move(1'b0);
  endtask

  // from select-dr: capture, shift n bits lsb first, stop in update
  task automatic scan(input logic ir, input logic [15:0] data,
                      input int n, output logic [15:0] got);
    got = '0;
    oe_seen = 1'b1;
    if (ir) move(1'b1);
    move(1'b0);
    move(1'b0);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, data[i]);
      got[i] = last_tdo;
      oe_seen = oe_seen & last_oe;
    end
    move(1'b1);
  endtask
endmodule

/* File: testbench/tb_top.sv */
// self-checking bench for the pulsed boundary-scan test port
`timescale 1ns/1ns
`include "pulse_scan_params.svh"
`define CHK(what, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("[FAIL] %s expected %h seen %h", what, exp, got); \
    end \
  end
module tb_top;
  localparam int BW = 8;
  logic          MCLK;
  logic          RESET_N;
  logic          CONFIG_DONE;
  logic [BW-1:0] CORE_OUT;
  logic [BW-1:0] PIN_IN;
  logic          TCK;
  logic          TMS;
  logic          TDI;
  logic          TDO;
  logic          TDO_OE;
  logic [BW-1:0] PIN_OUT;
  logic          TEST_ACTIVE;
  int            err_total;
  int            checked;
  logic [31:0]   seed;
  logic [BW-1:0] exp_pin;
  logic [BW-1:0] data;
  logic [15:0]   got;

  pulse_scan_tap #(.BSR_WIDTH(BW)) dut (
    .MCLK(MCLK), .RESET_N(RESET_N), .TCK(TCK), .TMS(TMS), .TDI(TDI),
    .TDO(TDO), .TDO_OE(TDO_OE), .CONFIG_DONE(CONFIG_DONE),
    .CORE_OUT(CORE_OUT), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
    .TEST_ACTIVE(TEST_ACTIVE)
  );

  jtag_tester jt (
    .MCLK(MCLK), .TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO(TDO),
    .TDO_OE(TDO_OE)
  );

  // 4 ns system clock
  always #2 MCLK = ~MCLK;

  // xorshift source, fixed start so runs repeat
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic rnd(output logic [BW-1:0] v);
    seed = xorshift(seed);
    v = seed[BW-1:0];
  endtask

  // fresh core data each look, so a pin wrongly on the core path shows it
  task automatic look(input logic core, input logic [BW-1:0] e);
    logic [BW-1:0] v;
    rnd(v);
    @(posedge MCLK);
    CORE_OUT <= v;
    repeat (8) @(posedge MCLK);
    `CHK("pin drive", core ? v : e, PIN_OUT)
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // a full run is about 3000 cycles; over thirteen times that means a hang
  initial begin
    repeat (40000) @(posedge MCLK);
    err_total++;
    $display("[FAIL] watchdog expected done seen hang");
    finish_test();
  end

  initial begin
    MCLK = 1'b0;
    RESET_N = 1'b0;
    CONFIG_DONE = 1'b0;
    CORE_OUT = '0;
    PIN_IN = '0;
    err_total = 0;
    checked = 0;
    seed = 32'h0000_B686;
    repeat (4) @(posedge MCLK);
    `CHK("reset outputs", 10'h000, {PIN_OUT, TEST_ACTIVE, TDO_OE})
    repeat (2) @(posedge MCLK);
    RESET_N <= 1'b1;
    repeat (4) @(posedge MCLK);
    repeat (4) look(1'b1, '0);
    $display("test reset and core path done");
    // plain code stands for dc-coupled links, the other two for ac
    @(posedge MCLK);
    CONFIG_DONE <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      jt.tap_reset();
      jt.move(1'b1);
      jt.scan(1'b1, {6'h00, m == 2 ? `IR_PLAIN_EXTEST :
              m ? `IR_TRAINING_TEST : `IR_PULSED_EXTEST}, 10, got);
      `CHK("ir capture", `IR_CAPTURE_VALUE, got[9:0])
      repeat (8) @(posedge MCLK);
      `CHK("test owns pins", 1'b1, TEST_ACTIVE)
      `CHK("tdo enable", 2'b10, {jt.oe_seen, TDO_OE})
      jt.move(1'b1);
      rnd(data);
      @(posedge MCLK);
      PIN_IN <= data;
      rnd(data);
      jt.scan(1'b0, {8'h00, data}, BW, got);
      `CHK("pin capture", {1'b1, PIN_IN}, {jt.oe_seen, got[BW-1:0]})
      exp_pin = data;
      look(1'b0, exp_pin);
      // model: first idle fall inverts; training keeps inverting; plain holds
      for (int k = 1; k <= 3; k++) begin
        jt.move(1'b0);
        if (m == 1 || (m == 0 && k == 1)) exp_pin = ~exp_pin;
        look(1'b0, exp_pin);
      end
      jt.move(1'b1);
      look(1'b0, data);
      $display("test external mode %0d done", m);
    end
    // reset in the middle of an external test hands the pins back
    @(posedge MCLK);
    RESET_N <= 1'b0;
    repeat (4) @(posedge MCLK);
    `CHK("mid reset", 10'h000, {PIN_OUT, TEST_ACTIVE, TDO_OE})
    RESET_N <= 1'b1;
    repeat (4) @(posedge MCLK);
    look(1'b1, '0);
    $display("test mid reset done");
    // unconfigured: CONFIG_DONE held low while the pulsed code is loaded
    @(posedge MCLK);
    CONFIG_DONE <= 1'b0;
    jt.tap_reset();
    jt.move(1'b1);
    jt.scan(1'b1, {6'h00, `IR_PULSED_EXTEST}, 10, got);
    repeat (8) @(posedge MCLK);
    `CHK("pulsed refused", 1'b0, TEST_ACTIVE)
    jt.move(1'b0);
    look(1'b1, '0);
    $display("test unconfigured done");
    finish_test();
  end
endmodule
